// File: gfmc_defines.vh
`ifndef GFMC_DEFINES_VH
`define GFMC_DEFINES_VH
// Number of configurable pins.
`define GFMC_NPINS        9
// Function codes, three bits per pin.
`define GFMC_FN_W         3
`define GFMC_FN_DISABLED  3'h0
`define GFMC_FN_INPUT     3'h1
`define GFMC_FN_OUTPUT    3'h2
`define GFMC_FN_NETSTAT   3'h3
`define GFMC_FN_GNSSPWR   3'h4
`define GFMC_FN_GNSSRDY   3'h5
`define GFMC_FN_RTCSYNC   3'h6
`define GFMC_FN_SIMDET    3'h7
// Audio pins keep their serial audio function under the same code as custom.
`define GFMC_FN_AUDIO     3'h3
// Register addresses.
`define GFMC_AW           4
`define GFMC_A_FUNC_LO    4'h0
`define GFMC_A_FUNC_HI    4'h1
`define GFMC_A_OUTVAL     4'h2
`define GFMC_A_INVAL      4'h3
`define GFMC_A_CLKCFG     4'h4
`define GFMC_A_SIMCFG     4'h5
`define GFMC_A_STATUS     4'h6
// Clock configuration fields.
`define GFMC_CK_EN        0
`define GFMC_CK_FAST      1
`define GFMC_CK_CONT      2
// Network status codes.
`define GFMC_NS_W         2
// Pin indices.
`define GFMC_P1           0
`define GFMC_P2           1
`define GFMC_P3           2
`define GFMC_P4           3
`define GFMC_P5           4
// Reset value of the SIM configuration.
`define GFMC_SIMCFG_RST   1'h0
`endif

// File: gfmc_sync.v
`include "gfmc_defines.vh"
// Three-stage synchroniser; output moves when the second and third stages agree.
module gfmc_sync #(
    parameter W = 9
) (
    // Clock and reset.
    input  wire         clk,
    input  wire         rstn,
    // Asynchronous input and filtered output.
    input  wire [W-1:0] asyncIn,
    output reg  [W-1:0] syncOut
);
    reg [W-1:0] s1_q;  // First stage, read only by the second.
    reg [W-1:0] s2_q;  // Second stage.
    reg [W-1:0] s3_q;  // Third stage.
    integer i;
    // The stages shift every cycle; each bit updates once two stages agree.
    always @(posedge clk) begin
        if (!rstn) begin
            s1_q    <= {W{1'b0}};
            s2_q    <= {W{1'b0}};
            s3_q    <= {W{1'b0}};
            syncOut <= {W{1'b0}};
        end else begin
            s1_q <= asyncIn;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    syncOut[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

// File: gfmc_clkgen.v
`include "gfmc_defines.vh"
// Square-wave generator for the master clock output pin.
// The output toggles once every halfLim cycles, so it runs at the system clock rate over twice halfLim; the
// system clock must be 52 MHz for true figures, and FAST_DIV/SLOW_DIV set it.
module gfmc_clkgen #(
    parameter CW       = 4,
    parameter FAST_DIV = 1,
    parameter SLOW_DIV = 2
) (
    // Clock and reset.
    input  wire clk,
    input  wire rstn,
    // Configuration.
    input  wire enable,
    input  wire fastSel,
    input  wire continuous,
    input  wire audioActive,
    // Clock pin.
    output reg  clkOut
);
    reg  [CW-1:0] cnt_q;    // Half-period counter.
    wire [CW-1:0] halfLim;  // Half period in system cycles.
    wire          run;      // Toggling is allowed.
    assign halfLim = fastSel ? FAST_DIV[CW-1:0] : SLOW_DIV[CW-1:0];
    assign run = enable & (continuous | audioActive);
    always @(posedge clk) begin
        if (!rstn) begin
            cnt_q  <= {CW{1'b0}};
            clkOut <= 1'b0;
        end else if (!run) begin
            cnt_q  <= {CW{1'b0}};
            clkOut <= 1'b0;  // Idle low while gated.
        end else if (cnt_q + {{(CW-1){1'b0}}, 1'b1} >= halfLim) begin
            cnt_q  <= {CW{1'b0}};
            clkOut <= ~clkOut;
        end else begin
            cnt_q <= cnt_q + {{(CW-1){1'b0}}, 1'b1};
        end
    end
endmodule

// File: gfmc_pinmux.v
`include "gfmc_defines.vh"
// Operation
// - clock output at 13 or 26 MHz
// - clock audio-gated or continuous
// - nine pins, each input, output or custom
// - network status on pins one to four
// - receiver supply enable, default pin two
// - receiver data ready only pin three
// - clock sync output only on pin four
// - SIM detect only on pin five
// - hot insertion enables and disables SIM
// - input mode reports sampled level
// - output mode drives commanded level
// - disabled pin tri-stated with pull-down
// - no-receiver variant disables pins two, three
module gfmc_pinmux #(
    parameter NP       = `GFMC_NPINS,
    parameter HAS_GNSS = 1,
    parameter FAST_DIV = 1,
    parameter SLOW_DIV = 2
) (
    // Clock and reset.
    input  wire                   clk,
    input  wire                   rstn,
    // Register port.
    input  wire [`GFMC_AW-1:0]    addr,
    input  wire [31:0]            wdata,
    input  wire                   wr,
    input  wire                   rd,
    output reg  [31:0]            rdata,
    // Configurable pins as three signals each, plus pull-down request.
    input  wire [NP-1:0]          pinIn,
    output reg  [NP-1:0]          pinOut,
    output reg  [NP-1:0]          pinOe,
    output reg  [NP-1:0]          pinPullDown,
    // Internal function sources and sinks.
    input  wire [`GFMC_NS_W-1:0]  netStatus,
    input  wire                   gnssPowerOn,
    input  wire                   rtcSync,
    input  wire [3:0]             audioTxOut,
    input  wire [3:0]             audioTxOe,
    output wire [3:0]             audioRxIn,
    output wire                   gnssDataReady,
    output wire                   simPresent,
    output wire                   simEnable,
    // Audio path and clock pin.
    input  wire                   audioActive,
    output wire                   masterClockOutPin
);
    ////////////////////////////////////////////////////////////////////////////
    // Configuration state.
    ////////////////////////////////////////////////////////////////////////////
    reg  [`GFMC_FN_W*NP-1:0] func_q;    // Function code per pin.
    reg  [`GFMC_FN_W*NP-1:0] func_d;    // Next function codes.
    reg  [NP-1:0]            outVal_q;  // Commanded output levels.
    reg  [2:0]               clkCfg_q;  // Clock enable, rate and mode.
    reg                      hotSwap_q; // SIM hot insertion mode.
    reg                      simEn_q;   // SIM interface enabled.
    reg                      simPrev_q; // Previous card presence.
    reg                      reject_q;  // Last function write was refused.
    reg                      reject_d;  // Next refusal flag.
    wire [NP-1:0]            pinSync;   // Synchronised pin levels.
    wire [`GFMC_FN_W*NP-1:0] funcReset; // Reset function codes.
    integer                  k, j;
    // Network status is a two-bit code shown as a blinking pattern; here the
    // pin simply shows the code's high bit.  Codes are generated outside.
    wire                     netLevel;
    assign netLevel = netStatus[`GFMC_NS_W-1];

    ////////////////////////////////////////////////////////////////////////////
    // Functions.
    ////////////////////////////////////////////////////////////////////////////
    // Tells whether a function code is allowed on a given pin.
    function allowed;
        input integer pin;
        input [`GFMC_FN_W-1:0] fn;
        begin
            case (fn)
                `GFMC_FN_DISABLED: allowed = 1'b1;
                `GFMC_FN_INPUT:    allowed = 1'b1;
                `GFMC_FN_OUTPUT:   allowed = 1'b1;
                `GFMC_FN_NETSTAT:  allowed = (pin <= `GFMC_P4) || (pin > `GFMC_P5);
                `GFMC_FN_GNSSPWR:  allowed = (pin <= `GFMC_P4) && (HAS_GNSS != 0);
                `GFMC_FN_GNSSRDY:  allowed = (pin == `GFMC_P3) && (HAS_GNSS != 0);
                `GFMC_FN_RTCSYNC:  allowed = (pin == `GFMC_P4);
                `GFMC_FN_SIMDET:   allowed = (pin == `GFMC_P5);
                default:           allowed = 1'b0;
            endcase
        end
    endfunction

    // Returns the reset function of a pin.
    function [`GFMC_FN_W-1:0] resetFn;
        input integer pin;
        begin
            case (pin)
                `GFMC_P1: resetFn = `GFMC_FN_DISABLED;
                `GFMC_P2: resetFn = HAS_GNSS ? `GFMC_FN_GNSSPWR : `GFMC_FN_DISABLED;
                `GFMC_P3: resetFn = HAS_GNSS ? `GFMC_FN_GNSSRDY : `GFMC_FN_DISABLED;
                `GFMC_P4: resetFn = `GFMC_FN_OUTPUT;
                `GFMC_P5: resetFn = `GFMC_FN_SIMDET;
                default:  resetFn = `GFMC_FN_AUDIO;
            endcase
        end
    endfunction

    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1) begin : gReset
            assign funcReset[`GFMC_FN_W*g +: `GFMC_FN_W] = resetFn(g);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Pin input synchroniser.
    ////////////////////////////////////////////////////////////////////////////
    gfmc_sync #(
        .W (NP)
    ) uSync (
        .clk     (clk),
        .rstn    (rstn),
        .asyncIn (pinIn),
        .syncOut (pinSync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Function write check.
    ////////////////////////////////////////////////////////////////////////////
    // Each pin field is three bits; the low word holds pins one to eight,
    // three-bit high word the ninth.  A field change that is not allowed refuses
    // the whole write.
    always @* begin
        func_d   = func_q;
        reject_d = reject_q;
        if (wr && (addr == `GFMC_A_FUNC_LO || addr == `GFMC_A_FUNC_HI)) begin
            for (k = 0; k < NP; k = k + 1) begin
                if ((addr == `GFMC_A_FUNC_LO) == (k < 8)) begin
                    func_d[`GFMC_FN_W*k +: `GFMC_FN_W] =
                        wdata[`GFMC_FN_W*(k%8) +: `GFMC_FN_W];
                end
            end
            reject_d = 1'b0;
            for (k = 0; k < NP; k = k + 1) begin
                if (!allowed(k, func_d[`GFMC_FN_W*k +: `GFMC_FN_W])) begin
                    reject_d = 1'b1;
                end
            end
            if (reject_d) begin
                func_d = func_q;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register writes and SIM control.
    ////////////////////////////////////////////////////////////////////////////
    // The function field format guarantees one function per pin at any time.
    always @(posedge clk) begin
        if (!rstn) begin
            func_q    <= funcReset;
            outVal_q  <= {NP{1'b0}};
            clkCfg_q  <= 3'h0;
            hotSwap_q <= `GFMC_SIMCFG_RST;
            simEn_q   <= 1'b1;
            simPrev_q <= 1'b0;
            reject_q  <= 1'b0;
        end else begin
            func_q   <= func_d;
            reject_q <= reject_d;
            simPrev_q <= pinSync[`GFMC_P5];
            if (wr && addr == `GFMC_A_OUTVAL) begin
                outVal_q <= wdata[NP-1:0];
            end
            if (wr && addr == `GFMC_A_CLKCFG) begin
                clkCfg_q <= wdata[2:0];
            end
            if (wr && addr == `GFMC_A_SIMCFG) begin
                hotSwap_q <= wdata[0];
            end
            if (hotSwap_q &&
                func_q[`GFMC_FN_W*`GFMC_P5 +: `GFMC_FN_W] == `GFMC_FN_SIMDET) begin
                if (pinSync[`GFMC_P5] && !simPrev_q) begin
                    simEn_q <= 1'b1;
                end else if (!pinSync[`GFMC_P5] && simPrev_q) begin
                    simEn_q <= 1'b0;
                end
            end else begin
                simEn_q <= 1'b1;  // Without hot swap the interface stays on.
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pin drivers.
    ////////////////////////////////////////////////////////////////////////////
    // Registered drivers so each pin output comes from a flip-flop.
    always @(posedge clk) begin
        if (!rstn) begin
            pinOut      <= {NP{1'b0}};
            pinOe       <= {NP{1'b0}};
            pinPullDown <= {NP{1'b0}};
        end else begin
            for (j = 0; j < NP; j = j + 1) begin
                pinOut[j]      <= 1'b0;
                pinOe[j]       <= 1'b0;
                pinPullDown[j] <= 1'b0;
                case (func_q[`GFMC_FN_W*j +: `GFMC_FN_W])
                    `GFMC_FN_DISABLED: pinPullDown[j] <= 1'b1;
                    `GFMC_FN_INPUT:    pinOe[j] <= 1'b0;
                    `GFMC_FN_OUTPUT: begin
                        pinOe[j]  <= 1'b1;
                        pinOut[j] <= outVal_q[j];
                    end
                    // status on pins one to four, audio on pins six to nine.
                    `GFMC_FN_NETSTAT: begin
                        if (j <= `GFMC_P4) begin
                            pinOe[j]  <= 1'b1;
                            pinOut[j] <= netLevel;
                        end else begin
                            pinOe[j]  <= audioTxOe[j-`GFMC_NPINS+4];
                            pinOut[j] <= audioTxOut[j-`GFMC_NPINS+4];
                        end
                    end
                    `GFMC_FN_GNSSPWR: begin
                        pinOe[j]  <= 1'b1;
                        pinOut[j] <= gnssPowerOn;
                    end
                    `GFMC_FN_RTCSYNC: begin
                        pinOe[j]  <= 1'b1;
                        pinOut[j] <= rtcSync;
                    end
                    default: pinOe[j] <= 1'b0;  // Sense functions only listen.
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sensed functions.
    ////////////////////////////////////////////////////////////////////////////
    // data ready sense.
    assign gnssDataReady = (func_q[`GFMC_FN_W*`GFMC_P3 +: `GFMC_FN_W] == `GFMC_FN_GNSSRDY)
                           & pinSync[`GFMC_P3];
    assign simPresent = (func_q[`GFMC_FN_W*`GFMC_P5 +: `GFMC_FN_W] == `GFMC_FN_SIMDET)
                        & pinSync[`GFMC_P5];
    assign simEnable  = simEn_q;
    assign audioRxIn  = pinSync[NP-1:NP-4];

    ////////////////////////////////////////////////////////////////////////////
    // Register reads.
    ////////////////////////////////////////////////////////////////////////////
    // Read data stand one cycle after the strobe; unmapped reads give zero.
    always @(posedge clk) begin
        if (!rstn) begin
            rdata <= 32'h00000000;
        end else if (rd) begin
            case (addr)
                `GFMC_A_FUNC_LO: rdata <= {8'h00, func_q[23:0]};
                `GFMC_A_FUNC_HI: rdata <= {29'h00000000, func_q[26:24]};
                `GFMC_A_OUTVAL:  rdata <= {23'h000000, outVal_q};
                `GFMC_A_INVAL:   rdata <= {23'h000000, pinSync};
                `GFMC_A_CLKCFG:  rdata <= {29'h00000000, clkCfg_q};
                `GFMC_A_SIMCFG:  rdata <= {31'h00000000, hotSwap_q};
                `GFMC_A_STATUS:  rdata <= {28'h0000000, simEn_q, simPresent,
                                           gnssDataReady, reject_q};
                default:         rdata <= 32'h00000000;
            endcase
        end else begin
            rdata <= 32'h00000000;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Master clock output.
    ////////////////////////////////////////////////////////////////////////////
    // clock generator.
    gfmc_clkgen #(
        .CW       (4),
        .FAST_DIV (FAST_DIV),
        .SLOW_DIV (SLOW_DIV)
    ) uClk (
        .clk         (clk),
        .rstn        (rstn),
        .enable      (clkCfg_q[`GFMC_CK_EN]),
        .fastSel     (clkCfg_q[`GFMC_CK_FAST]),
        .continuous  (clkCfg_q[`GFMC_CK_CONT]),
        .audioActive (audioActive),
        .clkOut      (masterClockOutPin)
    );
endmodule

// File: gfmc_pinmux_properties.sv
`include "gfmc_defines.vh"
// Checks clock, pin and SIM behaviour at the pin mux ports.
module gfmc_pinmux_properties #(
    parameter NP       = 9,
    parameter FAST_DIV = 1,
    parameter SLOW_DIV = 2
) (
    // Clock and reset.
    input wire                clk,
    input wire                rstn,
    // Register port.
    input wire [`GFMC_AW-1:0] addr,
    input wire [31:0]         wdata,
    input wire                wr,
    input wire                rd,
    input wire [31:0]         rdata,
    // Pin drivers.
    input wire [NP-1:0]       pinOe,
    input wire [NP-1:0]       pinPullDown,
    // SIM, audio and clock pin.
    input wire                simPresent,
    input wire                simEnable,
    input wire                audioActive,
    input wire                masterClockOutPin
);
    localparam [3:0] FD = FAST_DIV; // Fast half period.
    localparam [3:0] SD = SLOW_DIV; // Slow half period.
    reg [2:0] ckCfg_q;   // Shadow of the clock configuration.
    reg       ckKnown_q; // Clock has been configured.
    reg       hot_q;     // Shadow of the hot swap bit.
    reg       audio_q;   // Audio activity one cycle ago.
    reg       clkPrev_q; // Clock pin one cycle ago.
    reg [3:0] calm_q;    // Cycles since a configuration or audio change, held at 12.
    reg [3:0] run_q;     // Cycles at the current clock level.
    wire cfgWr = wr && (addr == `GFMC_A_CLKCFG || addr == `GFMC_A_SIMCFG);
    wire calm = calm_q >= 4'hC;
    wire gate = ckCfg_q[0] && (ckCfg_q[2] || audioActive);
    wire gateOn = ckKnown_q && gate;
    wire gateOff = ckKnown_q && !gate;
    wire [3:0] div = ckCfg_q[1] ? FD : SD;
    wire edgeSeen = masterClockOutPin != clkPrev_q;
    ////////////////////////////////////////
    // Tracks configuration and clock level lengths.
    always @(posedge clk) begin
        if (!rstn) begin
            ckCfg_q   <= 3'h0;
            ckKnown_q <= 1'b0;
            hot_q     <= `GFMC_SIMCFG_RST;
            audio_q   <= 1'b0;
            clkPrev_q <= 1'b0;
            calm_q    <= 4'h0;
            run_q     <= 4'h0;
        end else begin
            if (wr && addr == `GFMC_A_CLKCFG) begin
                ckCfg_q   <= wdata[2:0];
                ckKnown_q <= 1'b1;
            end
            if (wr && addr == `GFMC_A_SIMCFG) begin
                hot_q <= wdata[0];
            end
            audio_q   <= audioActive;
            clkPrev_q <= masterClockOutPin;
            calm_q    <= (cfgWr || audioActive != audio_q) ? 4'h0 : calm_q + {3'h0, !calm};
            run_q     <= edgeSeen ? 4'h1 : run_q + {3'h0, run_q != 4'hF};
        end
    end
    ////////////////////////////////////////
    a_rdata_idle: assert property (@(posedge clk) disable iff (!rstn)
        !$past(rd) |-> rdata == 32'h0) else $error("Read data without a read.");
    a_pull_nodrive: assert property (@(posedge clk) disable iff (!rstn)
        (pinPullDown & pinOe) == {NP{1'b0}}) else $error("Pull-down on a driven pin.");
    a_reset_quiet: assert property (@(posedge clk)
        !rstn |=> pinOe == {NP{1'b0}} && !masterClockOutPin && rdata == 32'h0)
        else $error("Outputs active after reset.");
    a_pin_default: assert property (@(posedge clk) disable iff (!rstn)
        !$past(rstn) |-> ##[1:2] (pinPullDown[0] && !pinOe[0] && pinOe[3] && !pinOe[2]))
        else $error("Pin defaults wrong after reset.");
    a_clk_idle: assert property (@(posedge clk) disable iff (!rstn)
        calm && gateOff |-> !masterClockOutPin) else $error("Clock pin not idle low.");
    a_clk_runs: assert property (@(posedge clk) disable iff (!rstn)
        calm && gateOn |-> run_q <= div) else $error("Clock pin stopped.");
    a_clk_half: assert property (@(posedge clk) disable iff (!rstn)
        calm && gateOn && edgeSeen |-> run_q == div) else $error("Clock half period wrong.");
    a_sim_insert: assert property (@(posedge clk) disable iff (!rstn)
        calm && hot_q && $rose(simPresent) |-> ##[1:2] simEnable)
        else $error("SIM not enabled on insertion.");
    a_sim_remove: assert property (@(posedge clk) disable iff (!rstn)
        calm && hot_q && $fell(simPresent) |-> ##[1:2] !simEnable)
        else $error("SIM not disabled on removal.");
    a_sim_plain: assert property (@(posedge clk) disable iff (!rstn)
        calm && !hot_q |-> simEnable) else $error("SIM off without hot swap.");
    c_clk_fast: cover property (@(posedge clk) calm && gateOn && ckCfg_q[1] && edgeSeen);
    c_sim_in: cover property (@(posedge clk) hot_q && $rose(simEnable));
    c_read: cover property (@(posedge clk) rd ##1 rdata != 32'h0);
endmodule
bind gfmc_pinmux gfmc_pinmux_properties #(
    .NP(NP), .FAST_DIV(FAST_DIV), .SLOW_DIV(SLOW_DIV)
) chk (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .pinOe(pinOe), .pinPullDown(pinPullDown),
    .simPresent(simPresent), .simEnable(simEnable), .audioActive(audioActive),
    .masterClockOutPin(masterClockOutPin)
);

// File: gfmc_pin_world.sv
// Resolves each pin from all its drivers.
module gfmc_pin_world #(
    parameter NP = 9
) (
    // Clock.
    input  wire          clk,
    // Device side of each pin.
    input  wire [NP-1:0] pinOut,
    input  wire [NP-1:0] pinOe,
    input  wire [NP-1:0] pinPullDown,
    // External parts driving the pins.
    input  wire [NP-1:0] extOe,
    input  wire [NP-1:0] extVal,
    // Resolved pin level.
    output wire [NP-1:0] pinLevel
);
    timeunit 1ns;
    timeprecision 1ps;
    reg [NP-1:0] float_q = {NP{1'b0}}; // Wandering level of an undriven pin.
    // A floating pin must not look stable.
    always @(posedge clk) begin
        float_q <= ~float_q;
    end
    assign pinLevel = (pinOe & pinOut) | (~pinOe & extOe & extVal)
        | (~pinOe & ~extOe & ~pinPullDown & float_q);
endmodule

// File: test_gfmc_pinmux.sv
`include "gfmc_defines.vh"
// Drives the pin mux over its register port.
module test_gfmc_pinmux;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FD = 1; // Fast half period in cycles.
    localparam int SD = 2; // Slow half period in cycles.
    localparam [31:0] DEF_LO = {8'h00, 3'h3, 3'h3, 3'h3, 3'h7, 3'h2, 3'h5, 3'h4, 3'h0};
    logic        clk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0;
    logic [3:0]  addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic [1:0]  netStatus = 2'h0;
    logic        gnssPowerOn = 1'b0, rtcSync = 1'b0, audioActive = 1'b0;
    logic [3:0]  audioTxOut = 4'h0, audioTxOe = 4'h0;
    logic [8:0]  extOe = 9'h000, extVal = 9'h000;
    wire  [31:0] rdata;
    wire  [8:0]  pinIn, pinOut, pinOe, pinPullDown;
    wire  [3:0]  audioRxIn;
    wire         gnssDataReady, simPresent, simEnable, masterClockOutPin;
    int          miscompares = 0, checkCount = 0, p, c, s, i, n, v;
    logic [31:0] d, w, fn [2];
    logic [3:0]  ra, ckTab [6] = '{4'h7, 4'h5, 4'h1, 4'h9, 4'hB, 4'hE};
    logic        ok, on, last;
    // Free-running clock.
    always #25 clk = ~clk;
    gfmc_pin_world #(.NP(9)) world (.clk(clk), .pinOut(pinOut), .pinOe(pinOe),
        .pinPullDown(pinPullDown), .extOe(extOe), .extVal(extVal), .pinLevel(pinIn));
    gfmc_pinmux #(.NP(9), .HAS_GNSS(1), .FAST_DIV(FD), .SLOW_DIV(SD)) uut (
        .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
        .pinPullDown(pinPullDown), .netStatus(netStatus), .gnssPowerOn(gnssPowerOn),
        .rtcSync(rtcSync), .audioTxOut(audioTxOut), .audioTxOe(audioTxOe),
        .audioRxIn(audioRxIn), .gnssDataReady(gnssDataReady), .simPresent(simPresent),
        .simEnable(simEnable), .audioActive(audioActive),
        .masterClockOutPin(masterClockOutPin));
    ////////////////////////////////////////
    // Tasks start and end just after an edge.
    task automatic waitCyc(input int k);
        repeat (k) @(posedge clk);
        #1;
    endtask
    task automatic wreg(input logic [3:0] a, input logic [31:0] x);
        addr <= a;
        wdata <= x;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rreg(input logic [3:0] a, output logic [31:0] x);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        x = rdata;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checkCount++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checkCount, miscompares);
        if (miscompares == 0 && checkCount > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Legal codes per pin.
    function automatic logic legal(input int pin, input int code);
        case (code)
            3: legal = pin != 4;
            4: legal = pin < 4;
            5: legal = pin == 2;
            6: legal = pin == 3;
            7: legal = pin == 4;
            default: legal = 1'b1;
        endcase
    endfunction
    ////////////////////////////////////////
    // Watchdog well beyond the test length.
    initial begin
        #1000000;
        miscompares++;
        conclude();
    end
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        waitCyc(1);
        rreg(`GFMC_A_FUNC_LO, d);
        check(d, DEF_LO);
        rreg(`GFMC_A_FUNC_HI, d);
        check(d, 32'h3);
        rreg(4'hF, d);
        check(d, 32'h0);
        check({30'h0, pinPullDown[0], pinOe[0]}, 32'h2);
        $display("test defaults done");
        fn[0] = DEF_LO;
        fn[1] = 32'h3;
        for (p = 0; p < 9; p++) begin
            for (c = 0; c < 8; c++) begin
                ra = (p == 8) ? `GFMC_A_FUNC_HI : `GFMC_A_FUNC_LO;
                s = 3 * (p % 8);
                w = (fn[p / 8] & ~(32'h7 << s)) | (32'(c) << s);
                ok = legal(p, c);
                wreg(ra, w);
                if (ok) fn[p / 8] = w;
                rreg(ra, d);
                check(d, fn[p / 8]);
                rreg(`GFMC_A_STATUS, d);
                check({31'h0, d[0]}, {31'h0, !ok});
            end
        end
        wreg(`GFMC_A_FUNC_HI, 32'h3);
        $display("test legality done");
        for (v = 0; v < 2; v++) begin
            wreg(`GFMC_A_FUNC_LO, DEF_LO | 32'h2);
            wreg(`GFMC_A_OUTVAL, 32'(v));
            waitCyc(2);
            check({30'h0, pinOe[0], pinOut[0]}, 32'(2 + v));
            wreg(`GFMC_A_FUNC_LO, DEF_LO | 32'h1);
            extOe[0] <= 1'b1;
            extVal[0] <= v[0];
            waitCyc(5);
            rreg(`GFMC_A_INVAL, d);
            check({30'h0, pinOe[0], d[0]}, 32'(v));
            extOe[0] <= 1'b0;
        end
        wreg(`GFMC_A_FUNC_LO, DEF_LO);
        waitCyc(5);
        rreg(`GFMC_A_INVAL, d);
        check({31'h0, d[0]}, 32'h0);
        $display("test input output done");
        wreg(`GFMC_A_FUNC_LO, (DEF_LO & ~32'hE07) | 32'hC03);
        extOe[2] <= 1'b1;
        for (v = 0; v < 4; v++) begin
            netStatus <= v[1:0];
            gnssPowerOn <= v[0];
            rtcSync <= v[1];
            extVal[2] <= v[0];
            waitCyc(5);
            check({28'h0, pinOe[3:0]}, 32'hB);
            check({29'h0, pinOut[3], pinOut[1:0]}, {29'h0, v[1], v[0], v[1]});
            rreg(`GFMC_A_STATUS, d);
            check({30'h0, gnssDataReady, d[1]}, {30'h0, v[0], v[0]});
        end
        extOe[2] <= 1'b0;
        $display("test functions done");
        wreg(`GFMC_A_FUNC_LO, DEF_LO);
        extOe[4] <= 1'b1;
        wreg(`GFMC_A_SIMCFG, 32'h1);
        waitCyc(16);
        for (v = 1; v >= 0; v--) begin
            extVal[4] <= v[0];
            waitCyc(16);
            check({30'h0, simPresent, simEnable}, 32'(3 * v));
        end
        wreg(`GFMC_A_SIMCFG, 32'h0);
        waitCyc(4);
        check({31'h0, simEnable}, 32'h1);
        $display("test sim done");
        for (i = 0; i < 6; i++) begin
            wreg(`GFMC_A_CLKCFG, {29'h0, ckTab[i][2:0]});
            audioActive <= ckTab[i][3];
            waitCyc(16);
            n = 0;
            last = masterClockOutPin;
            repeat (40) begin
                waitCyc(1);
                n += int'(masterClockOutPin !== last);
                last = masterClockOutPin;
            end
            on = ckTab[i][0] && (ckTab[i][2] || ckTab[i][3]);
            check(n, on ? 40 / (ckTab[i][1] ? FD : SD) : 0);
        end
        $display("test clock done");
        audioTxOe <= 4'hA;
        audioTxOut <= 4'h6;
        extOe[8:5] <= 4'h5;
        extVal[8:5] <= 4'h5;
        waitCyc(6);
        check({24'h0, pinOe[8:5], pinOut[8:5] & 4'hA}, 32'hA2);
        check({28'h0, audioRxIn & 4'h5}, 32'h5);
        $display("test audio done");
        conclude();
    end
endmodule
